// File: rtl/flash_lock_cmd.sv
// How it works
// R1: one volatile lock bit per region, all set to locked at power up
// R2: executed protection select sets the mode bit (security bit 7)
// R3: in individual mode lock bits decide protection, not the field
// R4: host sends write enable before protection select
// R5: protection select is opcode only, then enters individual mode
// R6: target is 64K block by A21-A16 or 4K sector by A21-A12
// R7: lock 36h / unlock 39h plus three address bytes set or clear bit
// R8: host sends write enable before each single lock or unlock
// R9: lock and ready/busy commands rejected unless select rises on boundary
// R10: status read 3Ch plus address returns the region lock bit
// R11: lock bit in first read byte, same region decoding as lock
// R12: status 1 means read only, 0 means read and write
// R13: chip lock 7Eh / chip unlock 98h set or clear every lock bit
// R14: host sends write enable before each chip lock or unlock
// R15: lock family has no effect until protection select executed
// R16: ready/busy on enables ready/busy on serial output in continuous_program_mode
// R17: ready/busy off in continuous_program_mode stops driving ready/busy
// R18: no-op only cancels a pending reset arm
// R19: reset works only right after reset arm; others void the arm
// R20: software reset aborts a running program or erase
// R21: reset during program flags the longer recovery
// R22: parameter read 5Ah, address, dummy, then stream table bytes
// R23: upper serial lanes are ignored
// R24: protection select bit once set stays set until rst_in clears it; after reset it is set again from the OTP strap in the first cycle or by protection select
// R25: in individual mode locked regions refuse program and erase
// R26: gated commands need write enable latch, which then clears
// R27: block or sector granularity from a fixed parameterised map
`timescale 1ns/100ps
module flash_lock_cmd (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic si_in,
  input wire logic [2:0] upper_serial_lanes_in,
  output logic so_out,
  output logic so_oe_out,
  // array side
  input wire logic protection_mode_select_otp_in,
  input wire logic prog_busy_in,
  input wire logic prog_is_program_in,
  input wire logic cont_prog_mode_in,
  input wire logic [23:0] prot_query_addr_in,
  output logic prot_locked_out,
  input wire logic [7:0] sfdp_data_in,
  output logic [7:0] sfdp_addr_out,
  // status
  output logic protection_mode_select_out,
  output logic wel_out,
  output logic ready_busy_en_out,
  output logic soft_reset_out,
  output logic abort_op_out,
  output logic recover_long_out
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_meta, cs_sync, cs_prev;
  logic sclk_meta, sclk_sync, sclk_prev;
  logic si_meta, si_sync;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      si_meta <= 1'b0;
      si_sync <= 1'b0;
    end else begin
      cs_meta <= cs_n_in;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      sclk_meta <= sclk_in;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      si_meta <= si_in;
      si_sync <= si_meta;
    end
  end

  logic cs_rise, cs_fall, sclk_rise, sclk_fall;
  assign cs_rise = cs_sync & ~cs_prev;
  assign cs_fall = ~cs_sync & cs_prev;
  assign sclk_rise = sclk_sync & ~sclk_prev & ~cs_sync;
  assign sclk_fall = ~sclk_sync & sclk_prev & ~cs_sync;

  // ----------------------------------------------------------------
  // command state
  // ----------------------------------------------------------------
  flash_lock_pkg::frame_s frame, next_frame;
  logic [flash_lock_pkg::REGION_COUNT-1:0] locks, next_locks;
  logic arm, next_arm, strap_done;
  logic next_protection_mode_select, next_wel, next_rb_en, next_so, next_so_oe;
  logic next_soft_reset, next_abort, next_recover_long, next_prot_locked;
  logic at_op, at_addr, rb_drive;
  logic [7:0] out_byte;

  always_comb begin
    next_frame = frame;
    next_locks = locks;
    next_arm = arm;
    next_protection_mode_select = protection_mode_select_out;
    next_wel = wel_out;
    next_rb_en = ready_busy_en_out;
    next_so = so_out;
    next_soft_reset = 1'b0;
    next_abort = 1'b0;
    next_recover_long = recover_long_out;
    out_byte = flash_lock_pkg::LOCK_BYTE_CLEAR;
    at_op = frame.bit_cnt == 3'h0
      && frame.byte_cnt == flash_lock_pkg::OPCODE_ONLY; // R9
    at_addr = frame.bit_cnt == 3'h0
      && frame.byte_cnt == flash_lock_pkg::WITH_ADDR; // R9
    if (!strap_done) begin
      next_protection_mode_select = protection_mode_select_out | protection_mode_select_otp_in; // R24
    end
    if (cs_fall) begin
      next_frame = flash_lock_pkg::FRAME_IDLE;
    end else if (sclk_rise) begin
      next_frame.shift_in = {frame.shift_in[6:0], si_sync}; // R23
      next_frame.bit_cnt = frame.bit_cnt + 3'h1;
      if (frame.bit_cnt == 3'h7) begin
        if (frame.byte_cnt != flash_lock_pkg::BYTE_CNT_MAX) begin
          next_frame.byte_cnt = frame.byte_cnt + 3'h1;
        end
        if (frame.byte_cnt == 3'h0) begin
          next_frame.opcode = next_frame.shift_in;
        end else if (frame.byte_cnt <= flash_lock_pkg::LAST_ADDR_BYTE) begin
          next_frame.addr = {frame.addr[15:0], next_frame.shift_in};
        end
        if (frame.opcode == flash_lock_pkg::OP_LOCK_STATUS && protection_mode_select_out
            && frame.byte_cnt == flash_lock_pkg::LAST_ADDR_BYTE) begin
          next_frame.out_phase = 1'b1; // R10 R15
        end
        if (frame.opcode == flash_lock_pkg::OP_PARAM_READ
            && frame.byte_cnt == flash_lock_pkg::LAST_DUMMY_BYTE) begin
          next_frame.out_phase = 1'b1; // R22
        end
      end
    end else if (sclk_fall && frame.out_phase) begin
      if (frame.bit_cnt == 3'h0) begin
        if (frame.opcode == flash_lock_pkg::OP_LOCK_STATUS) begin
          out_byte = locks[flash_lock_pkg::region_of(frame.addr)]
            ? flash_lock_pkg::LOCK_BYTE_SET
            : flash_lock_pkg::LOCK_BYTE_CLEAR; // R11 R12
        end else begin
          out_byte = sfdp_data_in; // R22
          next_frame.addr = frame.addr + 24'h000001;
        end
        next_so = out_byte[7];
        next_frame.tx = {out_byte[6:0], 1'b0};
      end else begin
        next_so = frame.tx[7];
        next_frame.tx = {frame.tx[6:0], 1'b0};
      end
    end
    if (cs_rise && frame.byte_cnt != 3'h0) begin
      next_arm = at_op && frame.opcode == flash_lock_pkg::OP_RESET_ARM; // R18 R19
      case (frame.opcode)
        flash_lock_pkg::OP_WRITE_ENABLE: begin
          if (at_op) begin
            next_wel = 1'b1;
          end
        end
        flash_lock_pkg::OP_PROT_SELECT: begin
          if (at_op && wel_out) begin
            next_protection_mode_select = 1'b1; // R2 R5
            next_wel = 1'b0; // R26
          end
        end
        flash_lock_pkg::OP_REGION_LOCK, flash_lock_pkg::OP_REGION_UNLOCK: begin
          if (at_addr && wel_out && protection_mode_select_out) begin
            next_locks[flash_lock_pkg::region_of(frame.addr)] =
              frame.opcode == flash_lock_pkg::OP_REGION_LOCK; // R6 R7 R27
            next_wel = 1'b0; // R26
          end
        end
        flash_lock_pkg::OP_CHIP_LOCK: begin
          if (at_op && wel_out && protection_mode_select_out) begin
            next_locks = '1; // R13
            next_wel = 1'b0; // R26
          end
        end
        flash_lock_pkg::OP_CHIP_UNLOCK: begin
          if (at_op && wel_out && protection_mode_select_out) begin
            next_locks = '0; // R13
            next_wel = 1'b0; // R26
          end
        end
        flash_lock_pkg::OP_RB_ON: begin
          if (at_op && cont_prog_mode_in) begin
            next_rb_en = 1'b1; // R16
          end
        end
        flash_lock_pkg::OP_RB_OFF: begin
          if (at_op && cont_prog_mode_in) begin
            next_rb_en = 1'b0; // R17
          end
        end
        flash_lock_pkg::OP_RESET: begin
          if (at_op && arm) begin
            next_soft_reset = 1'b1; // R19
            next_abort = prog_busy_in; // R20
            next_recover_long = prog_busy_in & prog_is_program_in; // R21
            next_wel = 1'b0;
            next_rb_en = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    rb_drive = ready_busy_en_out && cont_prog_mode_in
      && !next_frame.out_phase; // R16 R17
    next_so_oe = (next_frame.out_phase && !cs_sync) || rb_drive;
    if (rb_drive) begin
      next_so = !prog_busy_in;
    end
    next_prot_locked = protection_mode_select_out
      && locks[flash_lock_pkg::region_of(prot_query_addr_in)]; // R3 R25
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      frame <= flash_lock_pkg::FRAME_IDLE;
      locks <= flash_lock_pkg::LOCKS_RESET; // R1
      arm <= 1'b0;
      strap_done <= 1'b0;
      protection_mode_select_out <= 1'b0;
      wel_out <= 1'b0;
      ready_busy_en_out <= 1'b0;
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      soft_reset_out <= 1'b0;
      abort_op_out <= 1'b0;
      recover_long_out <= 1'b0;
      prot_locked_out <= 1'b0;
    end else begin
      frame <= next_frame;
      locks <= next_locks;
      arm <= next_arm;
      strap_done <= 1'b1;
      protection_mode_select_out <= next_protection_mode_select;
      wel_out <= next_wel;
      ready_busy_en_out <= next_rb_en;
      so_out <= next_so;
      so_oe_out <= next_so_oe;
      soft_reset_out <= next_soft_reset;
      abort_op_out <= next_abort;
      recover_long_out <= next_recover_long;
      prot_locked_out <= next_prot_locked;
    end
  end

  assign sfdp_addr_out = frame.addr[7:0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_protection_mode_select_sticky;
    protection_mode_select_out |=> protection_mode_select_out;
  endproperty
  a_protection_mode_select_sticky: assert property (p_protection_mode_select_sticky) // R24
    else $error("protection select bit fell");

  property p_protection_mode_select_set;
    cs_rise && frame.opcode == flash_lock_pkg::OP_PROT_SELECT && at_op
      && wel_out |=> protection_mode_select_out && !wel_out;
  endproperty
  a_protection_mode_select_set: assert property (p_protection_mode_select_set) // R2
    else $error("protection select not executed");

  property p_chip_lock;
    cs_rise && frame.opcode == flash_lock_pkg::OP_CHIP_LOCK && at_op
      && wel_out && protection_mode_select_out |=> &locks;
  endproperty
  a_chip_lock: assert property (p_chip_lock) // R13
    else $error("chip lock left a region unlocked");

  property p_chip_unlock;
    cs_rise && frame.opcode == flash_lock_pkg::OP_CHIP_UNLOCK && at_op
      && wel_out && protection_mode_select_out |=> locks == '0;
  endproperty
  a_chip_unlock: assert property (p_chip_unlock) // R13
    else $error("chip unlock left a region locked");

  property p_off_boundary;
    cs_rise && frame.bit_cnt != 3'h0 |=> $stable(locks) && !soft_reset_out
      && ready_busy_en_out == $past(ready_busy_en_out);
  endproperty
  a_off_boundary: assert property (p_off_boundary) // R9
    else $error("command executed off a byte boundary");

  property p_no_mode;
    !protection_mode_select_out && strap_done |=> $stable(locks);
  endproperty
  a_no_mode: assert property (p_no_mode) // R15
    else $error("lock bits changed outside individual mode");

  property p_wel_gate;
    !wel_out && strap_done |=> $stable(locks) && $stable(protection_mode_select_out);
  endproperty
  a_wel_gate: assert property (p_wel_gate) // R26
    else $error("gated command ran without write enable");

  property p_reset_armed;
    soft_reset_out |-> $past(arm) && !arm;
  endproperty
  a_reset_armed: assert property (p_reset_armed) // R19
    else $error("software reset without a pending arm");

  property p_no_op;
    cs_rise && frame.opcode == flash_lock_pkg::OP_NO_OP && at_op
      |=> !arm && $stable(locks) && $stable(wel_out) && !soft_reset_out;
  endproperty
  a_no_op: assert property (p_no_op) // R18
    else $error("no-op changed more than the reset arm");

  property p_ready_busy;
    rb_drive |=> so_oe_out && so_out == !$past(prog_busy_in);
  endproperty
  a_ready_busy: assert property (p_ready_busy) // R16
    else $error("ready/busy not driven on serial output");

  property p_locked_mode;
    prot_locked_out |-> $past(protection_mode_select_out);
  endproperty
  a_locked_mode: assert property (p_locked_mode) // R25
    else $error("region refused outside individual mode");

  c_soft_reset: cover property (soft_reset_out);
  c_chip_unlock: cover property (protection_mode_select_out && locks == '0);
  c_status_read: cover property (frame.out_phase
    && frame.opcode == flash_lock_pkg::OP_LOCK_STATUS);
  c_param_read: cover property (frame.out_phase
    && frame.opcode == flash_lock_pkg::OP_PARAM_READ);
endmodule // flash_lock_cmd

// File: rtl/flash_lock_pkg.sv
package flash_lock_pkg;
  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_PROT_SELECT = 8'h68;
  localparam logic [7:0] OP_REGION_LOCK = 8'h36;
  localparam logic [7:0] OP_REGION_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK_STATUS = 8'h3C;
  localparam logic [7:0] OP_CHIP_LOCK = 8'h7E;
  localparam logic [7:0] OP_CHIP_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RB_ON = 8'h70;
  localparam logic [7:0] OP_RB_OFF = 8'h80;
  localparam logic [7:0] OP_NO_OP = 8'h00;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_PARAM_READ = 8'h5A;
  // ----------------------------------------------------------------
  // frame byte counts
  // ----------------------------------------------------------------
  localparam logic [2:0] OPCODE_ONLY = 3'h1;
  localparam logic [2:0] WITH_ADDR = 3'h4;
  localparam logic [2:0] LAST_ADDR_BYTE = 3'h3;
  localparam logic [2:0] LAST_DUMMY_BYTE = 3'h4;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [7:0] LOCK_BYTE_SET = 8'hFF;
  localparam logic [7:0] LOCK_BYTE_CLEAR = 8'h00;
  // ----------------------------------------------------------------
  // region map: sector-lockable lowest and highest blocks
  // ----------------------------------------------------------------
  localparam int BLOCK_COUNT = 64;
  localparam int SECTORS_PER_BLOCK = 16;
  localparam int BLOCK_LSB = 16;
  localparam int BLOCK_W = 6;
  localparam int SECTOR_LSB = 12;
  localparam int SECTOR_W = 4;
  localparam int REGION_COUNT = BLOCK_COUNT - 2 + 2 * SECTORS_PER_BLOCK;
  localparam int REGION_W = 7;
  localparam int HIGH_SECTOR_BASE = SECTORS_PER_BLOCK + BLOCK_COUNT - 2;
  localparam logic [BLOCK_W-1:0] LOW_SECTOR_BLOCK = 6'h00;
  localparam logic [BLOCK_W-1:0] HIGH_SECTOR_BLOCK = 6'h3F;
  localparam logic [REGION_COUNT-1:0] LOCKS_RESET = '1;
  // ----------------------------------------------------------------
  // serial frame state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shift_in;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic out_phase;
    logic [7:0] tx;
  } frame_s;
  localparam frame_s FRAME_IDLE = '0;

  function automatic logic [REGION_W-1:0] region_of(input logic [23:0] a);
    logic [BLOCK_W-1:0] blk;
    logic [SECTOR_W-1:0] sec;
    blk = a[BLOCK_LSB +: BLOCK_W];
    sec = a[SECTOR_LSB +: SECTOR_W];
    if (blk == LOW_SECTOR_BLOCK) begin
      region_of = REGION_W'(sec);
    end else if (blk == HIGH_SECTOR_BLOCK) begin
      region_of = REGION_W'(HIGH_SECTOR_BASE) + REGION_W'(sec);
    end else begin
      region_of = REGION_W'(SECTORS_PER_BLOCK - 1) + REGION_W'(blk);
    end
  endfunction
endpackage

// File: test/flash_host_model.sv
`timescale 1ns/100ps
module flash_host_model (
  // clock
  input wire logic clk_sys_in,
  // serial pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in,
  // results
  output logic done_out,
  output logic oe_seen_out,
  output logic [7:0] rd_out
);
  // ------------------------------------------------------------
  // frame driver, sclk idles low
  // ------------------------------------------------------------
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
    done_out = 1'b0;
    oe_seen_out = 1'b0;
    rd_out = 8'h00;
  end
  task automatic xfer(input logic [39:0] h, input int nbits, input int nrd);
    logic [7:0] rd;
    logic oe;
    rd = 8'h00;
    oe = 1'b0;
    @(posedge clk_sys_in);
    cs_n_out <= 1'b0;
    for (int i = 0; i < nbits + 8 * nrd; i++) begin
      si_out <= (i < nbits) ? h[39-i] : ~si_out;
      repeat (12) @(posedge clk_sys_in);
      sclk_out <= 1'b1;
      if (i >= nbits) begin
        rd = {rd[6:0], so_in};
        oe = oe | so_oe_in;
      end
      repeat (13) @(posedge clk_sys_in);
      sclk_out <= 1'b0;
    end
    repeat (12) @(posedge clk_sys_in);
    cs_n_out <= 1'b1;
    si_out <= ~si_out;
    repeat (10) @(posedge clk_sys_in);
    oe_seen_out <= oe;
    rd_out <= oe ? rd : 8'h00;
    done_out <= 1'b1;
    @(posedge clk_sys_in);
    done_out <= 1'b0;
  endtask
endmodule // flash_host_model

// File: test/flash_lock_cmd_bench.sv
`timescale 1ns/100ps
module flash_lock_cmd_bench;
  logic clk_sys_in, rst_in, cs_n, sclk, si, so, so_oe, tgl;
  logic busy, is_prog, cp, protection_mode_select, wel, rben, srst, abrt, rlong, plock;
  logic done, oe_seen, s_rst, s_abt, otp;
  logic e_wp, e_wel, e_rb, e_rl, e_arm, e_rst, e_abt;
  logic [2:0] lanes;
  logic [7:0] sf_data, sf_addr, rd, op;
  logic [23:0] qaddr;
  logic [17:0] got, e;
  logic [31:0] seed;
  logic lk [0:93];
  logic [17:0] exp_q[$];
  string nm_q[$];
  string nm;
  int bad_count, total_checks;
  logic [31:0] steps [12] = '{32'h39003000, 32'h3C003FFF, 32'h3C004000,
    32'h3C002FFF, 32'h3905ABCD, 32'h3C050000, 32'h3C060000, 32'h39FFF000,
    32'h3C3FF000, 32'h3C3FE000, 32'h36050000, 32'h3C05FFFF};
  flash_lock_cmd flash_lock_cmd_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .si_in(si), .upper_serial_lanes_in(lanes),
    .so_out(so), .so_oe_out(so_oe), .protection_mode_select_otp_in(otp),
    .prog_busy_in(busy), .prog_is_program_in(is_prog),
    .cont_prog_mode_in(cp), .prot_query_addr_in(qaddr),
    .prot_locked_out(plock), .sfdp_data_in(sf_data),
    .sfdp_addr_out(sf_addr), .protection_mode_select_out(protection_mode_select), .wel_out(wel),
    .ready_busy_en_out(rben), .soft_reset_out(srst),
    .abort_op_out(abrt), .recover_long_out(rlong)
  );
  flash_host_model flash_host_model_inst (
    .clk_sys_in(clk_sys_in), .cs_n_out(cs_n), .sclk_out(sclk),
    .si_out(si), .so_in(so_oe ? so : tgl), .so_oe_in(so_oe),
    .done_out(done), .oe_seen_out(oe_seen), .rd_out(rd)
  );
  assign sf_data = ~sf_addr;
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    tgl <= ~tgl;
    lanes <= ~lanes ^ seed[4:2];
  end
  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int ridx(input logic [23:0] a);
    if (a[21:16] == 6'h00) return int'(a[15:12]);
    if (a[21:16] == 6'h3F) return 78 + int'(a[15:12]);
    return 15 + int'(a[21:16]);
  endfunction
  function automatic logic [17:0] pk(input logic oe, input logic [7:0] r,
                                     input logic [23:0] a);
    logic so_en;
    so_en = e_rb & cp;
    return {e_rst, e_abt, oe, e_wp, e_wel, e_rb, e_rl, e_wp & lk[ridx(a)],
            so_en, so_en & ~busy, r};
  endfunction
  task automatic cmd(input logic [7:0] op, input int nbits, input int nrd,
                     input string nm, input logic [23:0] a = 24'h000000);
    logic one, l, oe;
    logic [7:0] r;
    one = (nbits == 8);
    l = e_wel && e_wp;
    oe = 1'b0;
    r = 8'h00;
    if (one && op == flash_lock_pkg::OP_WRITE_ENABLE) e_wel = 1'b1;
    if (one && e_wel && op == flash_lock_pkg::OP_PROT_SELECT) begin
      e_wp = 1'b1;
      e_wel = 1'b0;
    end
    if (nbits == 32 && l && (op == flash_lock_pkg::OP_REGION_LOCK ||
        op == flash_lock_pkg::OP_REGION_UNLOCK)) begin
      lk[ridx(a)] = (op == flash_lock_pkg::OP_REGION_LOCK);
      e_wel = 1'b0;
    end
    if (one && l && (op == flash_lock_pkg::OP_CHIP_LOCK ||
        op == flash_lock_pkg::OP_CHIP_UNLOCK)) begin
      foreach (lk[i]) lk[i] = (op == flash_lock_pkg::OP_CHIP_LOCK);
      e_wel = 1'b0;
    end
    if (e_wp && nrd > 0 && op == flash_lock_pkg::OP_LOCK_STATUS) begin
      oe = 1'b1;
      r = lk[ridx(a)] ? 8'hFF : 8'h00;
    end
    if (op == flash_lock_pkg::OP_PARAM_READ) begin
      oe = 1'b1;
      r = ~(a[7:0] + 8'(nrd - 1));
    end
    if (one && cp && op == flash_lock_pkg::OP_RB_ON) e_rb = 1'b1;
    if (one && cp && op == flash_lock_pkg::OP_RB_OFF) e_rb = 1'b0;
    if (one && e_arm && op == flash_lock_pkg::OP_RESET) begin
      e_rst = 1'b1;
      e_abt = busy;
      e_rl = busy & is_prog;
      e_wel = 1'b0;
      e_rb = 1'b0;
    end
    if (nbits >= 8) e_arm = one && op == flash_lock_pkg::OP_RESET_ARM;
    exp_q.push_back(pk(oe, r, a));
    nm_q.push_back(nm);
    e_rst = 1'b0;
    e_abt = 1'b0;
    seed = xs(seed);
    qaddr <= a;
    flash_host_model_inst.xfer({op, a, seed[7:0]}, nbits, nrd);
  endtask
  task automatic gcmd(input logic [7:0] op, input int nbits,
                      input string nm, input logic [23:0] a = 24'h000000);
    cmd(flash_lock_pkg::OP_WRITE_ENABLE, 8, 0, "wel");
    cmd(op, nbits, 0, nm, a);
  endtask
  task automatic rstat(input string nm);
    seed = xs(seed);
    cmd(flash_lock_pkg::OP_LOCK_STATUS, 32, 1, nm, seed[23:0]);
  endtask
  task automatic setin(input logic c, input logic b, input logic p);
    cp <= c;
    busy <= b;
    is_prog <= p;
    @(posedge clk_sys_in);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // result monitor and watchdog
  // ------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (done) begin
      got = {s_rst, s_abt, oe_seen, protection_mode_select, wel, rben, rlong, plock, so_oe,
             so & so_oe, rd};
      e = exp_q.pop_front();
      nm = nm_q.pop_front();
      total_checks++;
      if (got !== e) begin
        bad_count++;
        $display("MISMATCH %s expected %h seen %h", nm, e, got);
      end
      s_rst = 1'b0;
      s_abt = 1'b0;
    end else begin
      s_rst = s_rst | srst;
      s_abt = s_abt | abrt;
    end
  end
  initial begin
    repeat (90000) @(posedge clk_sys_in);
    bad_count++;
    finish_test();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    {busy, is_prog, cp, tgl, s_rst, s_abt, otp} = '0;
    {e_wp, e_wel, e_rb, e_rl, e_arm, e_rst, e_abt} = '0;
    lanes = 3'h0;
    qaddr = 24'h000000;
    seed = 32'h01F4;
    bad_count = 0;
    total_checks = 0;
    foreach (lk[i]) lk[i] = 1'b1;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    cmd(flash_lock_pkg::OP_LOCK_STATUS, 32, 1, "rd_early");
    cmd(flash_lock_pkg::OP_PROT_SELECT, 8, 0, "sel_no_wel");
    gcmd(flash_lock_pkg::OP_PROT_SELECT, 8, "sel");
    for (int i = 0; i < 3; i++) rstat("powerup");
    $display("test mode_select finished");
    foreach (steps[i]) begin
      op = steps[i][31:24];
      if (op == flash_lock_pkg::OP_LOCK_STATUS) begin
        cmd(op, 32, 1, "region_rd", steps[i][23:0]);
      end else begin
        gcmd(op, 32, "region_wr", steps[i][23:0]);
      end
    end
    gcmd(flash_lock_pkg::OP_REGION_LOCK, 33, "lock_part");
    cmd(flash_lock_pkg::OP_REGION_LOCK, 40, 0, "lock_long");
    $display("test single_region finished");
    cmd(flash_lock_pkg::OP_CHIP_UNLOCK, 16, 0, "gang_long");
    cmd(flash_lock_pkg::OP_CHIP_UNLOCK, 8, 0, "gang_unlock");
    rstat("gang_rd0");
    cmd(flash_lock_pkg::OP_CHIP_LOCK, 8, 0, "gang_no_wel");
    gcmd(flash_lock_pkg::OP_CHIP_LOCK, 8, "gang_lock");
    rstat("gang_rd1");
    $display("test gang finished");
    cmd(flash_lock_pkg::OP_RB_ON, 8, 0, "rb_no_cp");
    setin(1'b1, 1'b0, 1'b0);
    cmd(flash_lock_pkg::OP_RB_ON, 8, 0, "rb_on");
    cmd(flash_lock_pkg::OP_RB_OFF, 5, 0, "rb_off_part");
    setin(1'b1, 1'b1, 1'b0);
    cmd(flash_lock_pkg::OP_NO_OP, 8, 0, "rb_busy");
    cmd(flash_lock_pkg::OP_RB_OFF, 8, 0, "rb_off");
    $display("test ready_busy finished");
    setin(1'b0, 1'b1, 1'b1);
    cmd(flash_lock_pkg::OP_RESET_ARM, 8, 0, "arm");
    cmd(flash_lock_pkg::OP_NO_OP, 8, 0, "nop");
    cmd(flash_lock_pkg::OP_RESET, 8, 0, "rst_void");
    cmd(flash_lock_pkg::OP_WRITE_ENABLE, 8, 0, "wel");
    cmd(flash_lock_pkg::OP_RESET_ARM, 8, 0, "arm");
    cmd(flash_lock_pkg::OP_RESET, 8, 0, "rst_prog");
    setin(1'b0, 1'b1, 1'b0);
    cmd(flash_lock_pkg::OP_RESET_ARM, 8, 0, "arm");
    cmd(flash_lock_pkg::OP_RESET, 8, 0, "rst_erase");
    setin(1'b0, 1'b0, 1'b0);
    rstat("lock_kept");
    gcmd(flash_lock_pkg::OP_CHIP_UNLOCK, 8, "pre_rst");
    otp <= 1'b1;
    rst_in <= 1'b1;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    {e_wel, e_rb, e_rl, e_arm} = '0;
    foreach (lk[i]) lk[i] = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rstat("rst_locked");
    $display("test soft_reset finished");
    seed = xs(seed);
    cmd(flash_lock_pkg::OP_PARAM_READ, 40, 2, "param", seed[23:0]);
    $display("test param_read finished");
    repeat (2) @(posedge clk_sys_in);
    finish_test();
  end
endmodule // flash_lock_cmd_bench
